// [dv/mpaf_link_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Network side: answers pause requests, sends pause frames and destinations
module mpaf_link_model (
   input  wire logic        ref_clk,
   input  wire logic        pauseReq_q,
   output logic             pauseSent,
   output logic             pauseRcv,
   output logic [15:0]      pauseTime,
   output logic             dstValid,
   output logic [47:0]      dstAddr
);
   int answerCyc = 0;

   // Released lines carry the inverse so no stale value can pass
   task automatic sendPause(input logic [15:0] t);
      @(posedge ref_clk);
      pauseRcv  <= 1'b1;
      pauseTime <= t;
      @(posedge ref_clk);
      pauseRcv  <= 1'b0;
      pauseTime <= ~t;
   endtask : sendPause

   task automatic sendDst(input logic [47:0] a);
      @(posedge ref_clk);
      dstValid <= 1'b1;
      dstAddr  <= a;
      @(posedge ref_clk);
      dstValid <= 1'b0;
      dstAddr  <= ~a;
   endtask : sendDst

   // Each pause request is answered by a maximum-time pause frame
   initial begin
      pauseSent = 1'b0;
      pauseRcv  = 1'b0;
      pauseTime = 16'h0000;
      dstValid  = 1'b0;
      dstAddr   = 48'h000000000000;
      forever begin
         @(posedge ref_clk);
         if (pauseReq_q === 1'b1) begin
            repeat (answerCyc) @(posedge ref_clk);
            pauseSent <= 1'b1;
            @(posedge ref_clk);
            pauseSent <= 1'b0;
         end
      end
   end
endmodule : mpaf_link_model
`default_nettype wire

// [dv/mpaf_pause_filter_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module mpaf_pause_filter_tb;
   logic                  ref_clk = 1'b0;
   logic                  nrst;
   logic                  flowEn;
   mpaf_pkg::mpaf_wbreq_t wbReq;
   mpaf_pkg::mpaf_wbrsp_t wbRsp_q;
   mpaf_pkg::mpaf_match_t match_q;
   logic                  pauseSent, pauseReq_q, pauseRcv, txHold_q, dstValid;
   logic [15:0]           pauseTime;
   logic [47:0]           dstAddr;
   logic [31:0]           r, r1;
   logic [4:0]            rdOfs [5] = '{5'h00, 5'h04, 5'h0C, 5'h10, 5'h14};
   int                    errorCnt = 0;
   int                    nTests = 0;
   int                    c;

   // Clock
   always #20 ref_clk = ~ref_clk;

   mpaf_pause_filter dut_u (.ref_clk(ref_clk), .nrst(nrst), .wbReq(wbReq), .wbRsp_q(wbRsp_q),
      .flowEn(flowEn), .pauseSent(pauseSent), .pauseReq_q(pauseReq_q), .pauseRcv(pauseRcv),
      .pauseTime(pauseTime), .txHold_q(txHold_q), .dstValid(dstValid), .dstAddr(dstAddr),
      .match_q(match_q));
   mpaf_link_model lk_u (.ref_clk(ref_clk), .pauseReq_q(pauseReq_q), .pauseSent(pauseSent),
      .pauseRcv(pauseRcv), .pauseTime(pauseTime), .dstValid(dstValid), .dstAddr(dstAddr));

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      nTests++;
      if (s !== e) begin
         errorCnt++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   // Classic cycle: hold until ack is sampled, then release for a cycle
   task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wbReq <= '{1'b1, 1'b1, we, a, 4'hF, d};
      do begin
         @(posedge ref_clk);
         n++;
      end while (wbRsp_q.ack !== 1'b1 && n < 20);
      if (wbRsp_q.ack !== 1'b1) errorCnt++;
      r = wbRsp_q.dat;
      wbReq <= '0;
      @(posedge ref_clk);
   endtask : wb

   // Timer read allowing one slot tick between write and read
   task automatic rdNear(input logic [4:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h00000000);
      chk((r === e - 32'h1) ? e : r, e);
   endtask : rdNear

   task automatic entry(input logic [4:0] i, input logic [31:0] hi, input logic [31:0] lo);
      wb(1'b1, mpaf_pkg::OFS_INDEX, {27'h0, i});
      wb(1'b1, mpaf_pkg::OFS_ADDR_HI, hi);
      wb(1'b1, mpaf_pkg::OFS_ADDR_LO, lo);
   endtask : entry

   // Lookup; m masks the compared bits of accept, drop, channel
   task automatic look(input logic [47:0] a, input logic [4:0] e, input logic [4:0] m);
      lk_u.sendDst(a);
      c = 0;
      do begin
         @(posedge ref_clk);
         c++;
      end while (match_q.done !== 1'b1 && c < 4);
      chk({26'h0, match_q.done, {match_q.accept, match_q.drop, match_q.chan} & m},
          {26'h0, 1'b1, e});
   endtask : look

   task automatic reportAndStop;
      $display("comparisons %0d mismatches %0d", nTests, errorCnt);
      if (errorCnt == 0 && nTests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : reportAndStop

   // Watchdog
   initial begin
      repeat (20000) @(posedge ref_clk);
      errorCnt++;
      reportAndStop();
   end

   // Tests
   initial begin
      nrst   = 1'b0;
      flowEn = 1'b0;
      wbReq  = '0;
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      foreach (rdOfs[i]) begin
         wb(1'b0, rdOfs[i], 32'h00000000);
         chk(r, 32'h00000000);
      end
      wb(1'b1, mpaf_pkg::OFS_RX_PAUSE, 32'hFFFF1234);
      rdNear(mpaf_pkg::OFS_RX_PAUSE, 32'h00001234);
      wb(1'b1, mpaf_pkg::OFS_TX_PAUSE, 32'hABCD0005);
      rdNear(mpaf_pkg::OFS_TX_PAUSE, 32'h00000005);
      wb(1'b1, mpaf_pkg::OFS_TX_PAUSE, 32'h00000000);
      $display("test registers done");
      for (int i = 0; i < 32; i++) entry(5'(i), 32'h00000000, 32'h00000000);
      entry(5'h03, 32'h22334455, 32'h001D0011);
      wb(1'b0, mpaf_pkg::OFS_ADDR_LO, 32'h00000000);
      chk(r, 32'h001D0011);
      wb(1'b0, mpaf_pkg::OFS_ADDR_HI, 32'h00000000);
      chk(r, 32'h22334455);
      entry(5'h04, 32'h22334466, 32'h00170011);
      entry(5'h05, 32'h22334477, 32'h000D0011);
      look(48'h554433221100, 5'h15, 5'h1F);
      look(48'h664433221100, 5'h08, 5'h1F);
      look(48'h774433221100, 5'h00, 5'h18);
      $display("test address table done");
      lk_u.sendPause(16'h0002);
      @(posedge ref_clk);
      chk({31'h0, txHold_q}, 32'h1);
      c = 0;
      while (txHold_q !== 1'b0 && c < 400) begin
         @(posedge ref_clk);
         c++;
      end
      chk({31'h0, 1'(c >= 128 && c <= 258)}, 32'h1);
      wb(1'b0, mpaf_pkg::OFS_TX_PAUSE, 32'h00000000);
      chk(r, 32'h00000000);
      lk_u.sendPause(16'h0003);
      lk_u.sendPause(16'h0040);
      rdNear(mpaf_pkg::OFS_TX_PAUSE, 32'h00000040);
      lk_u.sendPause(16'h0000);
      $display("test transmit pause done");
      flowEn <= 1'b1;
      lk_u.answerCyc = 5;
      wb(1'b1, mpaf_pkg::OFS_RX_PAUSE, 32'h00000001);
      c = 0;
      while (pauseReq_q !== 1'b1 && c < 300) begin
         @(posedge ref_clk);
         c++;
      end
      chk({31'h0, 1'(c < 300)}, 32'h1);
      repeat (10) @(posedge ref_clk);
      rdNear(mpaf_pkg::OFS_RX_PAUSE, 32'h0000FF00);
      r1 = r;
      repeat (381) @(posedge ref_clk);
      wb(1'b0, mpaf_pkg::OFS_RX_PAUSE, 32'h00000000);
      chk(r1 - r, 32'h00000003);
      $display("test receive pause done");
      reportAndStop();
   end
endmodule : mpaf_pause_filter_tb
`default_nettype wire

// [hw/mpaf_pause_filter.sv]
// Summary of operation
// [RULE_01] Sending a maximum-time pause frame loads the receive pause timer with FF00h.
// [RULE_02] Receive pause timer decrements by one each slot time while nonzero.
// [RULE_03] Receive timer reaching zero requests another pause frame, then reload repeats.
// [RULE_04] A received pause frame loads the transmit pause timer with its time.
// [RULE_05] Transmit timer counts down per slot; transmission held until it is zero.
// [RULE_06] Receive timer count reads at bits 15:0, upper bits zero.
// [RULE_07] Transmit timer count reads at bits 15:0, upper bits zero.
// [RULE_08] Bit 20 valid flag; invalid entries take no part in matching.
// [RULE_09] Software should clear valid on every unused table entry.
// [RULE_10] Valid entry with match bit 19 clear drops packets to its address.
// [RULE_11] Valid entry with match bit set accepts packets to its address.
// [RULE_12] Channel bits 18:16 of matching entry choose the receive channel.
// [RULE_13] Channel field is ignored when the match bit is clear.
// [RULE_14] Low word: address byte 0 at bits 15:8, byte 1 at 7:0.
// [RULE_15] High word: address bytes 2,3,4,5 at bits 31:24,23:16,15:8,7:0.
// [RULE_16] Write index, then high word, then low word; low write commits entry.
// [RULE_17] Software initialises all 32 entries before enabling reception.
// [RULE_18] A pause frame while transmit timer is nonzero reloads it.
`timescale 1ns/1ps
`default_nettype none
module mpaf_pause_filter (
   input  wire logic                 ref_clk,
   input  wire logic                 nrst,
   input  wire mpaf_pkg::mpaf_wbreq_t wbReq,
   output var  mpaf_pkg::mpaf_wbrsp_t wbRsp_q,
   input  wire logic                 flowEn,
   input  wire logic                 pauseSent,
   output logic                      pauseReq_q,
   input  wire logic                 pauseRcv,
   input  wire logic [15:0]          pauseTime,
   output logic                      txHold_q,
   input  wire logic                 dstValid,
   input  wire logic [47:0]          dstAddr,
   output var  mpaf_pkg::mpaf_match_t match_q
);
   logic [7:0]            slotCnt_q;
   logic [7:0]            slotCnt_d;
   logic                  tick;
   logic [15:0]           rxTmr_q;
   logic [15:0]           rxTmr_d;
   logic [15:0]           txTmr_q;
   logic [15:0]           txTmr_d;
   logic                  pauseReq_d;
   logic                  txHold_d;
   logic [31:0]           addrHi_q;
   logic [31:0]           addrHi_d;
   logic [4:0]            index_q;
   logic [4:0]            index_d;
   logic [31:0]           valid_q;
   logic [31:0]           valid_d;
   mpaf_pkg::mpaf_entry_t table_q [mpaf_pkg::ENTRIES];
   mpaf_pkg::mpaf_entry_t newEntry;
   logic                  tblWe;
   mpaf_pkg::mpaf_wbrsp_t wbRsp_d;
   mpaf_pkg::mpaf_match_t match_d;
   logic                  acc;
   logic                  wrEn;
   logic [31:0]           loWord;
   logic [31:0]           loNew;
   logic [31:0]           filtHit;
   logic [31:0]           accHit;
   logic [2:0]            accChan;

   // Merge write data into a word under byte enables
   function automatic logic [31:0] wbMerge(input logic [31:0] old, input logic [31:0] nv,
                                           input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nv[8*b +: 8];
         end
      end
      return r;
   endfunction : wbMerge

   // Bus access phases: request seen, then write lands with ack
   assign acc  = wbReq.cyc && wbReq.stb && !wbRsp_q.ack;
   assign wrEn = wbReq.cyc && wbReq.stb && wbReq.we && wbRsp_q.ack;
   assign tick = (slotCnt_q == mpaf_pkg::SLOT_LAST);

   // Selected entry as a low word
   always_comb begin
      loWord = {11'h000, valid_q[index_q], table_q[index_q].matchOrDrop, // RULE_14
                table_q[index_q].chan, table_q[index_q].addr[7:0],
                table_q[index_q].addr[15:8]};
      loNew  = wbMerge(loWord, wbReq.dat, wbReq.sel);
   end

   // Slot time divider and pause timers
   always_comb begin
      slotCnt_d  = tick ? mpaf_pkg::SLOT_RESET : slotCnt_q + 8'h01;
      rxTmr_d    = rxTmr_q;
      txTmr_d    = txTmr_q;
      if (pauseSent) begin
         rxTmr_d = mpaf_pkg::PAUSE_LOAD; // RULE_01
      end else if (wrEn && wbReq.adr == mpaf_pkg::OFS_RX_PAUSE) begin
         rxTmr_d = 16'(wbMerge({16'h0000, rxTmr_q}, wbReq.dat, wbReq.sel));
      end else if (tick && rxTmr_q != mpaf_pkg::PAUSE_ZERO) begin
         rxTmr_d = rxTmr_q - 16'h0001; // RULE_02
      end
      // Zero reached: ask the transmitter for another pause frame
      pauseReq_d = flowEn && tick && rxTmr_q == 16'h0001 && !pauseSent // RULE_03
                   && !(wrEn && wbReq.adr == mpaf_pkg::OFS_RX_PAUSE);
      if (pauseRcv) begin
         txTmr_d = pauseTime; // RULE_04 RULE_18
      end else if (wrEn && wbReq.adr == mpaf_pkg::OFS_TX_PAUSE) begin
         txTmr_d = 16'(wbMerge({16'h0000, txTmr_q}, wbReq.dat, wbReq.sel));
      end else if (tick && txTmr_q != mpaf_pkg::PAUSE_ZERO) begin
         txTmr_d = txTmr_q - 16'h0001; // RULE_05
      end
      txHold_d = (txTmr_d != mpaf_pkg::PAUSE_ZERO); // RULE_05
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         slotCnt_q  <= mpaf_pkg::SLOT_RESET;
         rxTmr_q    <= mpaf_pkg::PAUSE_ZERO;
         txTmr_q    <= mpaf_pkg::PAUSE_ZERO;
         pauseReq_q <= 1'b0;
         txHold_q   <= 1'b0;
      end else begin
         slotCnt_q  <= slotCnt_d;
         rxTmr_q    <= rxTmr_d;
         txTmr_q    <= txTmr_d;
         pauseReq_q <= pauseReq_d;
         txHold_q   <= txHold_d;
      end
   end

   // Index, staged high word and entry commit on the low write
   always_comb begin
      index_d  = index_q;
      addrHi_d = addrHi_q;
      valid_d  = valid_q;
      tblWe    = 1'b0;
      newEntry.matchOrDrop = loNew[mpaf_pkg::MATCH_BIT];
      newEntry.chan        = loNew[mpaf_pkg::CHAN_LSB +: 3];
      newEntry.addr        = {addrHi_q[7:0], addrHi_q[15:8], addrHi_q[23:16], // RULE_15
                              addrHi_q[31:24], loNew[7:0], loNew[15:8]}; // RULE_14
      if (wrEn && wbReq.adr == mpaf_pkg::OFS_INDEX) begin
         index_d = 5'(wbMerge({27'h0000000, index_q}, wbReq.dat, wbReq.sel));
      end else if (wrEn && wbReq.adr == mpaf_pkg::OFS_ADDR_HI) begin
         addrHi_d = wbMerge(addrHi_q, wbReq.dat, wbReq.sel);
      end else if (wrEn && wbReq.adr == mpaf_pkg::OFS_ADDR_LO) begin
         tblWe = 1'b1; // RULE_16
         valid_d[index_q] = loNew[mpaf_pkg::VALID_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         index_q  <= 5'h00;
         addrHi_q <= 32'h00000000;
         valid_q  <= 32'h00000000;
      end else begin
         index_q  <= index_d;
         addrHi_q <= addrHi_d;
         valid_q  <= valid_d;
      end
   end

   // Address table storage, no reset; valid bits gate it
   always_ff @(posedge ref_clk) begin
      if (tblWe) begin
         table_q[index_q] <= newEntry;
      end
   end

   // Destination lookup; a dropping entry wins, then the lowest accepting one
   always_comb begin
      accChan = 3'h0;
      for (int i = 0; i < mpaf_pkg::ENTRIES; i++) begin
         filtHit[i] = valid_q[i] && !table_q[i].matchOrDrop // RULE_08 RULE_10
                      && table_q[i].addr == dstAddr;
         accHit[i]  = valid_q[i] && table_q[i].matchOrDrop // RULE_08 RULE_11
                      && table_q[i].addr == dstAddr;
      end
      for (int i = mpaf_pkg::ENTRIES - 1; i >= 0; i--) begin
         if (accHit[i]) begin
            accChan = table_q[i].chan; // RULE_12 RULE_13
         end
      end
      match_d.done   = dstValid;
      match_d.drop   = dstValid && (|filtHit); // RULE_10
      match_d.accept = dstValid && !(|filtHit) && (|accHit); // RULE_11
      match_d.chan   = match_d.accept ? accChan : 3'h0; // RULE_13
   end

   // Bus answer: one wait state, unmapped reads give zero
   always_comb begin
      wbRsp_d.ack = acc;
      wbRsp_d.dat = 32'h00000000;
      if (acc && !wbReq.we) begin
         if (wbReq.adr == mpaf_pkg::OFS_RX_PAUSE) begin
            wbRsp_d.dat = {16'h0000, rxTmr_q}; // RULE_06
         end else if (wbReq.adr == mpaf_pkg::OFS_TX_PAUSE) begin
            wbRsp_d.dat = {16'h0000, txTmr_q}; // RULE_07
         end else if (wbReq.adr == mpaf_pkg::OFS_ADDR_LO) begin
            wbRsp_d.dat = loWord;
         end else if (wbReq.adr == mpaf_pkg::OFS_ADDR_HI) begin
            wbRsp_d.dat = addrHi_q;
         end else if (wbReq.adr == mpaf_pkg::OFS_INDEX) begin
            wbRsp_d.dat = {27'h0000000, index_q};
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wbRsp_q <= '0;
         match_q <= '0;
      end else begin
         wbRsp_q <= wbRsp_d;
         match_q <= match_d;
      end
   end

   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   sequence s_rdRx;
      acc && !wbReq.we && wbReq.adr == mpaf_pkg::OFS_RX_PAUSE;
   endsequence
   sequence s_rdTx;
      acc && !wbReq.we && wbReq.adr == mpaf_pkg::OFS_TX_PAUSE;
   endsequence

   property p_rxLoad;
      pauseSent |=> rxTmr_q == 16'hFF00;
   endproperty
   a_rxLoad: assert property (p_rxLoad) else $error("rx pause load wrong"); // RULE_01

   property p_rxDec;
      tick && !pauseSent && !wrEn && rxTmr_q != 16'h0000 |=> rxTmr_q == $past(rxTmr_q) - 16'h0001;
   endproperty
   a_rxDec: assert property (p_rxDec) else $error("rx pause no decrement"); // RULE_02

   property p_rxReq;
      flowEn && tick && rxTmr_q == 16'h0001 && !pauseSent && !wrEn
         |=> pauseReq_q && rxTmr_q == 16'h0000 ##1 !pauseReq_q;
   endproperty
   a_rxReq: assert property (p_rxReq) else $error("no pause request at zero"); // RULE_03

   property p_txLoad;
      pauseRcv |=> txTmr_q == $past(pauseTime) && txHold_q == (txTmr_q != 16'h0000);
   endproperty
   a_txLoad: assert property (p_txLoad) else $error("tx pause load wrong"); // RULE_04

   property p_txHold;
      txHold_q == (txTmr_q != 16'h0000);
   endproperty
   a_txHold: assert property (p_txHold) else $error("tx hold mismatch"); // RULE_05

   property p_rdRx;
      s_rdRx |=> wbRsp_q.ack && wbRsp_q.dat == {16'h0000, $past(rxTmr_q)};
   endproperty
   a_rdRx: assert property (p_rdRx) else $error("rx pause read wrong"); // RULE_06

   property p_rdTx;
      s_rdTx |=> wbRsp_q.ack && wbRsp_q.dat == {16'h0000, $past(txTmr_q)};
   endproperty
   a_rdTx: assert property (p_rdTx) else $error("tx pause read wrong"); // RULE_07

   property p_noHit;
      dstValid && !(|filtHit) && !(|accHit) |=> match_q.done && !match_q.accept && !match_q.drop;
   endproperty
   a_noHit: assert property (p_noHit) else $error("match without valid hit"); // RULE_08

   property p_drop;
      dstValid && (|filtHit) |=> match_q.drop && !match_q.accept && match_q.chan == 3'h0;
   endproperty
   a_drop: assert property (p_drop) else $error("filter entry not dropped"); // RULE_10

   property p_accept;
      dstValid && !(|filtHit) && (|accHit) |=> match_q.accept && match_q.chan == $past(accChan);
   endproperty
   a_accept: assert property (p_accept) else $error("match entry not accepted"); // RULE_11

   property p_commit;
      wrEn && wbReq.adr == mpaf_pkg::OFS_ADDR_LO |=> valid_q[$past(index_q)] == $past(loNew[20]);
   endproperty
   a_commit: assert property (p_commit) else $error("entry not committed"); // RULE_16

   property p_txDec;
      tick && !pauseRcv && !wrEn && txTmr_q != 16'h0000 |=> txTmr_q == $past(txTmr_q) - 16'h0001;
   endproperty
   a_txDec: assert property (p_txDec) else $error("tx pause no decrement"); // RULE_05

   property p_rxStay;
      !tick && !pauseSent && !wrEn |=> $stable(rxTmr_q);
   endproperty
   a_rxStay: assert property (p_rxStay) else $error("rx pause moved off slot"); // RULE_02

   property p_txStay;
      !tick && !pauseRcv && !wrEn |=> $stable(txTmr_q) && $stable(txHold_q);
   endproperty
   a_txStay: assert property (p_txStay) else $error("tx pause moved off slot"); // RULE_05

   property p_txReload;
      pauseRcv && txTmr_q != 16'h0000 |=> txTmr_q == $past(pauseTime);
   endproperty
   a_txReload: assert property (p_txReload) else $error("tx pause not reloaded"); // RULE_18
endmodule : mpaf_pause_filter
`default_nettype wire

// [hw/mpaf_pkg.sv]
`default_nettype none
package mpaf_pkg;
   // Register byte offsets
   localparam logic [4:0]  OFS_RX_PAUSE = 5'h00;
   localparam logic [4:0]  OFS_TX_PAUSE = 5'h04;
   localparam logic [4:0]  OFS_ADDR_LO  = 5'h08;
   localparam logic [4:0]  OFS_ADDR_HI  = 5'h0C;
   localparam logic [4:0]  OFS_INDEX    = 5'h10;
   // Low address word fields and table size
   localparam int          VALID_BIT    = 20;
   localparam int          MATCH_BIT    = 19;
   localparam int          CHAN_LSB     = 16;
   localparam int          ENTRIES      = 32;
   // Pause timer reload after sending a pause frame
   localparam logic [15:0] PAUSE_LOAD   = 16'hFF00;
   localparam logic [15:0] PAUSE_ZERO   = 16'h0000;
   // Slot time in ns and its length in ref_clk cycles
   localparam int          SLOT_NS      = 5120;
   localparam int          CLK_NS       = 40;
   localparam int          SLOT_CYC     = (SLOT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0]  SLOT_LAST    = 8'(SLOT_CYC - 1);
   localparam logic [7:0]  SLOT_RESET   = 8'h00;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [4:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } mpaf_wbreq_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } mpaf_wbrsp_t;

   typedef struct packed {
      logic        done;
      logic        accept;
      logic        drop;
      logic [2:0]  chan;
   } mpaf_match_t;

   typedef struct packed {
      logic        matchOrDrop;
      logic [2:0]  chan;
      logic [47:0] addr;
   } mpaf_entry_t;
endpackage : mpaf_pkg
`default_nettype wire
